// *** core/dsr_defs.svh ***
// Object indices, status bit positions, reset values, limits and timing counts.
`ifndef DSR_DEFS_SVH
`define DSR_DEFS_SVH

`define DSR_IDX_STATUS     16'h2025
`define DSR_IDX_RANGE_END  16'h2028
`define DSR_IDX_HOLD_TQ    16'h202B
`define DSR_IDX_ROT_SENSE  16'h202C
`define DSR_IDX_REV_PAUSE  16'h202E
`define DSR_IDX_SPEED      16'h2030
`define DSR_IDX_PEAK_TQ    16'h2031
`define DSR_IDX_TORQUE     16'h2033
`define DSR_IDX_U_LOGIC    16'h203A
`define DSR_IDX_U_DRIVE    16'h203B
`define DSR_IDX_U_THRESH   16'h203C

`define DSR_ST_TARGET      0
`define DSR_ST_DRAG        1
`define DSR_ST_REV_JOG     2
`define DSR_ST_FWD_JOG     3
`define DSR_ST_POWER       4
`define DSR_ST_ABORTED     5
`define DSR_ST_RUNNING     6
`define DSR_ST_OVER_TEMP   7
`define DSR_ST_OPPOSITE    8
`define DSR_ST_ERROR       9
`define DSR_ST_BLOCKED     10
`define DSR_ST_MANUAL      11
`define DSR_ST_BAD_TARGET  12
`define DSR_ST_POWER_LOST  13
`define DSR_ST_POS_LIMIT   14
`define DSR_ST_NEG_LIMIT   15

`define DSR_RANGE_END_RST  32'h0001_9000
`define DSR_HOLD_TQ_RST    16'h0064
`define DSR_ROT_SENSE_RST  16'h0000
`define DSR_REV_PAUSE_RST  16'h000A
`define DSR_U_THRESH_RST   16'h00B9

`define DSR_INCR_PER_REV   33'sh0_0000_0400
`define DSR_RANGE_MIN_REV  33'sh0_0000_0003
`define DSR_RANGE_MAX_REV  33'sh0_0000_00FD
`define DSR_REV_PAUSE_MIN  16'h000A
`define DSR_REV_PAUSE_MAX  16'h2710
`define DSR_U_THRESH_MIN   16'h00B4
`define DSR_U_THRESH_MAX   16'h00F0
`define DSR_U_RUN_FLOOR    16'h00AF

`define DSR_MS_NS          1000000
`define DSR_CLK_NS         4
`define DSR_CYC_PER_MS     (`DSR_MS_NS / `DSR_CLK_NS)

`endif

// *** core/dsr_pkg.sv ***
// Types shared by the drive status and run parameter block.
package dsr_pkg;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] index;
    logic [31:0] wdata;
  } dsr_obj_req_t;

  typedef struct packed {
    logic        ack;
    logic        abort;
    logic [31:0] rdata;
  } dsr_obj_rsp_t;

  typedef struct packed {
    logic signed [15:0] speed;
    logic [15:0]        torque;
    logic [15:0]        u_logic;
    logic [15:0]        u_drive;
  } dsr_meas_t;

  typedef struct packed {
    logic target_reached;
    logic drag_error;
    logic rev_jog;
    logic fwd_jog;
    logic aborted;
    logic running;
    logic over_temp;
    logic opposite;
    logic error;
    logic blocked;
    logic manual_disp;
    logic bad_target;
    logic pos_limit;
    logic neg_limit;
  } dsr_evt_t;

endpackage : dsr_pkg

// *** core/dsr_peak_torque.sv ***
// Peak torque tracker for the most recent run.
`timescale 1ns/1ns
`default_nettype none
module dsr_peak_torque (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Run phases and torque.
  input  wire logic        run_start,
  input  wire logic        measuring,
  input  wire logic [15:0] torque,
  // Result.
  output logic      [15:0] peak
);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      peak <= 16'h0000;
    end else if (run_start) begin
      peak <= 16'h0000;
    end else if (measuring && torque > peak) begin
      peak <= torque;
    end
  end
endmodule : dsr_peak_torque
`default_nettype wire

// *** core/dsr_reversal_pause.sv ***
// Idle period timer started on each reversal of rotation.
`include "dsr_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module dsr_reversal_pause #(
  parameter int CYC_PER_MS = `DSR_CYC_PER_MS
) (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Reversal request and period in milliseconds.
  input  wire logic        reverse,
  input  wire logic [15:0] pause_ms,
  // Pause in progress.
  output logic             idle
);
  logic [31:0] prescale;
  logic [15:0] ms_left;
  wire         ms_tick = (prescale == 32'(CYC_PER_MS - 1));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prescale <= 32'h0000_0000;
      ms_left  <= 16'h0000;
    end else if (reverse) begin
      prescale <= 32'h0000_0000;
      ms_left  <= pause_ms;
    end else if (ms_left != 16'h0000) begin
      prescale <= ms_tick ? 32'h0000_0000 : prescale + 32'h0000_0001;
      ms_left  <= ms_tick ? ms_left - 16'h0001 : ms_left;
    end
  end

  assign idle = (ms_left != 16'h0000);
endmodule : dsr_reversal_pause
`default_nettype wire

// *** core/dsr_drive_status.sv ***
// Drive status word, run parameters and measurement objects.
//
// Contract
// - status bits 0-3: target, drag, jog keys.
// - bits 4-7: power, aborted, running, overtemperature.
// - bits 8-11: opposite, error, blocked, displacement.
// - bits 12-15: bad target, power lost, limits.
// - range end within position+3..+253 revs, standstill.
// - rotation sense 0 or 1, standstill only.
// - standstill torque capped by writable value.
// - reversal pause 10..10000 ms, default 10.
// - logic supply voltage read-only, 0.1 V.
// - drive supply voltage read-only, 0.1 V.
// - power flag compares voltage with threshold 180..240 at standstill, with floor 175 while running.
// - refuse run start unless voltage above threshold.
// - shaft speed signed read-only rpm.
`include "dsr_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module dsr_drive_status
  import dsr_pkg::*;
#(
  parameter int CYC_PER_MS = `DSR_CYC_PER_MS
) (
  // Clock and reset.
  input  wire logic               clock,
  input  wire logic               rst_n,
  // Object access from the fieldbus master.
  input  wire dsr_obj_req_t       obj_req,
  output dsr_obj_rsp_t            obj_rsp,
  // Drive state from the motor controller.
  input  wire dsr_evt_t           evt,
  input  wire dsr_meas_t          meas,
  input  wire logic signed [31:0] actual_pos,
  input  wire logic               startup_phase,
  input  wire logic               braking_phase,
  input  wire logic               dir_change,
  input  wire logic               err_ack,
  // Run start requests and answers.
  input  wire logic               start_pos_req,
  input  wire logic               start_man_req,
  output logic                    start_grant,
  output logic                    start_refused,
  // Settings driven to the motor controller.
  output logic signed [31:0]      range_end,
  output logic        [15:0]      hold_torque_cap,
  output logic                    rotation_ccw,
  output logic                    reversal_idle,
  output logic                    motor_power_ok
);

  // These hold the settings and internal state, plus the combinational status word, read value and next answer.
  logic        [15:0] status_word;
  logic        [15:0] hold_tq;
  logic        [15:0] rot_sense;
  logic        [15:0] rev_pause;
  logic        [15:0] u_thresh;
  logic               power_lost;
  logic               running_q;
  logic        [15:0] peak_tq;
  logic        [31:0] rd_val;
  dsr_obj_rsp_t       next_rsp;

  // Request decode.
  // A request lasts one cycle; its answer is registered and stands for the next cycle.
  wire        req      = obj_req.valid;
  wire        wr       = obj_req.valid & obj_req.write;
  wire [15:0] idx      = obj_req.index;
  wire [31:0] wd       = obj_req.wdata;
  wire        standstill = ~evt.running;

  // Each object index has one select line.
  wire hit_status = (idx == `DSR_IDX_STATUS);
  wire hit_range  = (idx == `DSR_IDX_RANGE_END);
  wire hit_hold   = (idx == `DSR_IDX_HOLD_TQ);
  wire hit_rot    = (idx == `DSR_IDX_ROT_SENSE);
  wire hit_pause  = (idx == `DSR_IDX_REV_PAUSE);
  wire hit_speed  = (idx == `DSR_IDX_SPEED);
  wire hit_peak   = (idx == `DSR_IDX_PEAK_TQ);
  wire hit_torque = (idx == `DSR_IDX_TORQUE);
  wire hit_ulogic = (idx == `DSR_IDX_U_LOGIC);
  wire hit_udrive = (idx == `DSR_IDX_U_DRIVE);
  wire hit_thresh = (idx == `DSR_IDX_U_THRESH);

  // Known objects are split by whether a write may reach them.
  wire hit_rw = hit_range | hit_hold | hit_rot | hit_pause | hit_thresh;
  wire hit_ro = hit_status | hit_speed | hit_peak | hit_torque
              | hit_ulogic | hit_udrive;

  // Permitted window for the range end, relative to the actual position.
  // The sums are 33 bits wide so that a position near the top cannot wrap.
  wire signed [32:0] pos_ext  = {actual_pos[31], actual_pos};
  wire signed [32:0] wd_ext   = {wd[31], wd};
  wire signed [32:0] range_lo = pos_ext + `DSR_RANGE_MIN_REV * `DSR_INCR_PER_REV;
  wire signed [32:0] range_hi = pos_ext + `DSR_RANGE_MAX_REV * `DSR_INCR_PER_REV;
  wire range_in = (wd_ext >= range_lo) && (wd_ext <= range_hi);

  // Value checks for each writable object.
  // A 16-bit object refuses a write whose upper half is not zero.
  wire [15:0] wd16     = wd[15:0];
  wire        upper0   = (wd[31:16] == 16'h0000);
  wire ok_range  = standstill & range_in;
  wire ok_hold   = upper0;
  wire ok_rot    = standstill & upper0 & (wd16[15:1] == 15'h0000);
  wire pause_lo  = (wd16 >= `DSR_REV_PAUSE_MIN);
  wire pause_hi  = (wd16 <= `DSR_REV_PAUSE_MAX);
  wire thresh_lo = (wd16 >= `DSR_U_THRESH_MIN);
  wire thresh_hi = (wd16 <= `DSR_U_THRESH_MAX);
  wire ok_pause  = upper0 & pause_lo & pause_hi;
  wire ok_thresh = upper0 & thresh_lo & thresh_hi;

  wire wr_range  = wr & hit_range & ok_range;
  wire wr_hold   = wr & hit_hold & ok_hold;
  wire wr_rot    = wr & hit_rot & ok_rot;
  wire wr_pause  = wr & hit_pause & ok_pause;
  wire wr_thresh = wr & hit_thresh & ok_thresh;
  wire wr_taken  = wr_range | wr_hold | wr_rot | wr_pause | wr_thresh;

  // Motor power: strict threshold at rest, lower floor once running.
  // A run under way rides through a sag that would block a new start.
  wire pwr_rest = (meas.u_drive > u_thresh);
  wire pwr_run  = (meas.u_drive >= `DSR_U_RUN_FLOOR);
  assign motor_power_ok = evt.running ? pwr_run : pwr_rest;

  // Run start gating.
  // Both kinds of run share one gate, answered in the cycle of the request.
  wire start_req = start_pos_req | start_man_req;
  assign start_grant   = start_req & standstill & pwr_rest;
  assign start_refused = start_req & ~(standstill & pwr_rest);

  // Status word assembly.
  // Bit 4 follows the live power flag, bit 13 the latched loss.
  always_comb begin
    status_word = 16'h0000;
    status_word[`DSR_ST_TARGET]     = evt.target_reached;
    status_word[`DSR_ST_DRAG]       = evt.drag_error;
    status_word[`DSR_ST_REV_JOG]    = evt.rev_jog;
    status_word[`DSR_ST_FWD_JOG]    = evt.fwd_jog;
    status_word[`DSR_ST_POWER]      = motor_power_ok;
    status_word[`DSR_ST_ABORTED]    = evt.aborted;
    status_word[`DSR_ST_RUNNING]    = evt.running;
    status_word[`DSR_ST_OVER_TEMP]  = evt.over_temp;
    status_word[`DSR_ST_OPPOSITE]   = evt.opposite;
    status_word[`DSR_ST_ERROR]      = evt.error;
    status_word[`DSR_ST_BLOCKED]    = evt.blocked;
    status_word[`DSR_ST_MANUAL]     = evt.manual_disp;
    status_word[`DSR_ST_BAD_TARGET] = evt.bad_target;
    status_word[`DSR_ST_POWER_LOST] = power_lost;
    status_word[`DSR_ST_POS_LIMIT]  = evt.pos_limit;
    status_word[`DSR_ST_NEG_LIMIT]  = evt.neg_limit;
  end

  // Read selection.
  // Sixteen-bit objects read with a zero upper half; the speed is sign extended.
  wire [31:0] rd_status = {16'h0000, status_word};
  wire [31:0] rd_range  = range_end;
  wire [31:0] rd_hold   = {16'h0000, hold_tq};
  wire [31:0] rd_rot    = {16'h0000, rot_sense};
  wire [31:0] rd_pause  = {16'h0000, rev_pause};
  wire [31:0] rd_speed  = {{16{meas.speed[15]}}, meas.speed};
  wire [31:0] rd_peak   = {16'h0000, peak_tq};
  wire [31:0] rd_torque = {16'h0000, meas.torque};
  wire [31:0] rd_ulogic = {16'h0000, meas.u_logic};
  wire [31:0] rd_udrive = {16'h0000, meas.u_drive};
  wire [31:0] rd_thresh = {16'h0000, u_thresh};

  // The addressed object's value is read, or zero for an unknown index.
  assign rd_val = hit_status ? rd_status :
                  hit_range  ? rd_range  :
                  hit_hold   ? rd_hold   :
                  hit_rot    ? rd_rot    :
                  hit_pause  ? rd_pause  :
                  hit_speed  ? rd_speed  :
                  hit_peak   ? rd_peak   :
                  hit_torque ? rd_torque :
                  hit_ulogic ? rd_ulogic :
                  hit_udrive ? rd_udrive :
                  hit_thresh ? rd_thresh : 32'h0000_0000;

  // Answer: reads of known objects and accepted writes are acknowledged.
  // Every request gets exactly one of acknowledge or abort, never both.
  wire rd_good = req & ~obj_req.write & (hit_rw | hit_ro);
  always_comb begin
    next_rsp.ack   = rd_good | wr_taken;
    next_rsp.abort = req & ~(rd_good | wr_taken);
    next_rsp.rdata = rd_good ? rd_val : 32'h0000_0000;
  end

  // The answer is held in a register for one cycle.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      obj_rsp <= '0;
    end else begin
      obj_rsp <= next_rsp;
    end
  end

  // Writable settings; a refused write leaves the stored value as it was.
  wire signed [31:0] next_range_end = wr_range ? wd : range_end;
  wire        [15:0] next_hold_tq   = wr_hold ? wd16 : hold_tq;
  wire        [15:0] next_rot_sense = wr_rot ? wd16 : rot_sense;
  wire        [15:0] next_rev_pause = wr_pause ? wd16 : rev_pause;
  wire        [15:0] next_u_thresh  = wr_thresh ? wd16 : u_thresh;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      range_end <= `DSR_RANGE_END_RST;
    end else begin
      range_end <= next_range_end;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hold_tq <= `DSR_HOLD_TQ_RST;
    end else begin
      hold_tq <= next_hold_tq;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rot_sense <= `DSR_ROT_SENSE_RST;
    end else begin
      rot_sense <= next_rot_sense;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rev_pause <= `DSR_REV_PAUSE_RST;
    end else begin
      rev_pause <= next_rev_pause;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      u_thresh <= `DSR_U_THRESH_RST;
    end else begin
      u_thresh <= next_u_thresh;
    end
  end

  // Power-lost flag holds until acknowledged; a new loss wins over the clear.
  // The flag also latches at power-up when the motor supply is still low.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      power_lost <= 1'b0;
    end else if (!motor_power_ok) begin
      power_lost <= 1'b1;
    end else if (err_ack) begin
      power_lost <= 1'b0;
    end
  end

  // Run edge detection for the peak tracker.
  // The rising run edge clears the peak so each run reports its own maximum.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      running_q <= 1'b0;
    end else begin
      running_q <= evt.running;
    end
  end

  // Torque counts only while the run travels at steady drive.
  wire run_start = evt.running & ~running_q;
  wire measuring = evt.running & ~startup_phase & ~braking_phase;

  // Start-up and braking torque stay out of the peak.
  dsr_peak_torque u_peak (
    .clock     (clock),
    .rst_n     (rst_n),
    .run_start (run_start),
    .measuring (measuring),
    .torque    (meas.torque),
    .peak      (peak_tq)
  );

  // A new reversal restarts the pause from the full period.
  dsr_reversal_pause #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_pause (
    .clock    (clock),
    .rst_n    (rst_n),
    .reverse  (dir_change),
    .pause_ms (rev_pause),
    .idle     (reversal_idle)
  );

  // Settings out to the motor controller.
  // Only bit 0 of the rotation sense reaches the motor controller.
  assign hold_torque_cap = hold_tq;
  assign rotation_ccw    = rot_sense[0];

endmodule : dsr_drive_status
`default_nettype wire

// *** sim/dsr_drive_status_properties.sv ***
// Port checks for the drive status block.
`timescale 1ns/1ns
`default_nettype none
module dsr_drive_status_properties
  import dsr_pkg::*;
(
  // Clock and reset.
  input wire logic               clock,
  input wire logic               rst_n,
  // Object access and drive state.
  input wire dsr_obj_req_t       obj_req,
  input wire dsr_obj_rsp_t       obj_rsp,
  input wire dsr_evt_t           evt,
  input wire dsr_meas_t          meas,
  input wire logic               dir_change,
  // Run start and settings.
  input wire logic               start_pos_req,
  input wire logic               start_man_req,
  input wire logic               start_grant,
  input wire logic               start_refused,
  input wire logic signed [31:0] range_end,
  input wire logic               rotation_ccw,
  input wire logic               reversal_idle,
  input wire logic               motor_power_ok
);
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  sequence status_read_s;
    obj_req.valid && !obj_req.write && obj_req.index == 16'h2025;
  endsequence
  sequence status_ans_s;
    obj_rsp.ack && obj_rsp.rdata[15:14] == {$past(evt.neg_limit), $past(evt.pos_limit)}
      && obj_rsp.rdata[6:4] == {$past(evt.running), $past(evt.aborted), $past(motor_power_ok)}
      && obj_rsp.rdata[0] == $past(evt.target_reached);
  endsequence
  answer_once_a: assert property (obj_req.valid |=> obj_rsp.ack ^ obj_rsp.abort)
    else $error("request not answered exactly once");
  no_spurious_a: assert property (!obj_req.valid |=> !obj_rsp.ack && !obj_rsp.abort)
    else $error("answer without request");
  status_map_a: assert property (status_read_s |=> status_ans_s)
    else $error("status word bits misplaced");
  abort_zero_a: assert property (obj_rsp.abort |-> obj_rsp.rdata == 32'h0)
    else $error("refused access returns data");
  grant_excl_a: assert property ((start_pos_req || start_man_req) |-> start_grant != start_refused)
    else $error("start answer not exclusive");
  grant_cond_a: assert property (start_grant |-> !evt.running && meas.u_drive > 16'h00B4)
    else $error("start granted without voltage");
  sag_ok_a: assert property (evt.running |-> motor_power_ok == (meas.u_drive >= 16'h00AF))
    else $error("running voltage floor wrong");
  power_low_a: assert property (!evt.running && meas.u_drive <= 16'h00B4 |-> !motor_power_ok)
    else $error("power flag above threshold floor");
  stand_lock_a: assert property (evt.running |=> $stable(range_end) && $stable(rotation_ccw))
    else $error("standstill setting changed while running");
  pause_start_a: assert property (dir_change |=> reversal_idle [*8])
    else $error("reversal pause too short");
endmodule : dsr_drive_status_properties

bind dsr_drive_status dsr_drive_status_properties u_props (
  .clock(clock), .rst_n(rst_n), .obj_req(obj_req), .obj_rsp(obj_rsp), .evt(evt),
  .meas(meas), .dir_change(dir_change), .start_pos_req(start_pos_req),
  .start_man_req(start_man_req), .start_grant(start_grant), .start_refused(start_refused),
  .range_end(range_end), .rotation_ccw(rotation_ccw), .reversal_idle(reversal_idle),
  .motor_power_ok(motor_power_ok)
);
`default_nettype wire

// *** sim/dsr_master_model.sv ***
// Fieldbus master model that issues object reads and writes.
`timescale 1ns/1ns
`default_nettype none
module dsr_master_model
  import dsr_pkg::*;
(
  // Clock.
  input  wire logic         clock,
  // Object access.
  output var dsr_obj_req_t  obj_req,
  input  wire dsr_obj_rsp_t obj_rsp
);
  initial begin
    obj_req = '0;
  end
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                      output logic ab, output logic [31:0] rd, output logic ok);
    int n;
    @(negedge clock);
    obj_req = '{'1, wr, idx, wd}; // Callers send undefined bits as zero.
    @(negedge clock);
    obj_req = '{'0, wr, ~idx, ~wd};
    ok = '0;
    ab = '0;
    rd = '0;
    for (n = 0; n < 4 && ok !== 1'h1; n++) begin
      if (obj_rsp.ack === 1'h1 || obj_rsp.abort === 1'h1) begin
        ok = '1;
        ab = obj_rsp.abort;
        rd = obj_rsp.rdata;
      end else begin
        @(negedge clock);
      end
    end
  endtask : xfer
endmodule : dsr_master_model
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench for the drive status block.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import dsr_pkg::*;
  typedef struct {logic wr; logic [15:0] idx; logic [31:0] wd; logic ab; logic [31:0] rd;} dsr_row_t;
  logic               clock = '0;
  logic               rst_n = '0;
  dsr_obj_req_t       obj_req;
  dsr_obj_rsp_t       obj_rsp;
  dsr_evt_t           evt = '0;
  dsr_meas_t          meas = '{16'hFFFB, 16'h0123, 16'h00F0, 16'h00FA};
  logic signed [31:0] actual_pos = 32'h0;
  logic               startup_phase = '0;
  logic               braking_phase = '0;
  logic               dir_change = '0;
  logic               err_ack = '0;
  logic               start_pos_req = '0;
  logic               start_man_req = '0;
  logic               start_grant, start_refused, rotation_ccw, reversal_idle, motor_power_ok;
  logic signed [31:0] range_end;
  logic        [15:0] hold_torque_cap;
  logic               ab, ok;
  logic        [31:0] rd;
  int                 fail_count = 0;
  int                 cmp_count = 0;
  int                 n;
  int                 st_pos[14] = '{0, 1, 2, 3, 5, 6, 7, 8, 9, 10, 11, 12, 14, 15};
  dsr_row_t rows[$] = '{
    '{'0, 16'h2028, '0, '0, 32'h19000}, '{'0, 16'h203C, '0, '0, 32'hB9},
    '{'0, 16'h202B, '0, '0, 32'h64}, '{'0, 16'h2025, '0, '0, 32'h10},
    '{'0, 16'h2030, '0, '0, 32'hFFFFFFFB}, '{'0, 16'h203A, '0, '0, 32'hF0},
    '{'0, 16'h203B, '0, '0, 32'hFA}, '{'1, 16'h2025, 32'h1, '1, '0},
    '{'1, 16'h2030, 32'h1, '1, '0}, '{'0, 16'h2029, '0, '1, '0},
    '{'1, 16'h202E, 32'h9, '1, '0}, '{'1, 16'h202E, 32'h2711, '1, '0},
    '{'1, 16'h202E, 32'h2710, '0, '0}, '{'0, 16'h202E, '0, '0, 32'h2710},
    '{'1, 16'h202E, 32'hA, '0, '0}, '{'1, 16'h203C, 32'hB3, '1, '0},
    '{'1, 16'h203C, 32'hF1, '1, '0}, '{'1, 16'h203C, 32'hF0, '0, '0},
    '{'0, 16'h203C, '0, '0, 32'hF0}, '{'1, 16'h203C, 32'hB9, '0, '0},
    '{'1, 16'h202C, 32'h2, '1, '0}, '{'1, 16'h202C, 32'h1, '0, '0},
    '{'0, 16'h202C, '0, '0, 32'h1}, '{'1, 16'h2028, 32'hBFF, '1, '0},
    '{'1, 16'h2028, 32'hC00, '0, '0}, '{'1, 16'h2028, 32'h3F401, '1, '0},
    '{'1, 16'h2028, 32'h3F400, '0, '0}, '{'0, 16'h2028, '0, '0, 32'h3F400},
    '{'0, 16'h2033, '0, '0, 32'h123},
    '{'1, 16'h202B, 32'h10000, '1, '0}, '{'1, 16'h202B, 32'hFFFF, '0, '0}};

  dsr_master_model u_master (.clock(clock), .obj_req(obj_req), .obj_rsp(obj_rsp));
  dsr_drive_status #(.CYC_PER_MS(4)) u_dut (
    .clock(clock), .rst_n(rst_n), .obj_req(obj_req), .obj_rsp(obj_rsp), .evt(evt),
    .meas(meas), .actual_pos(actual_pos), .startup_phase(startup_phase),
    .braking_phase(braking_phase), .dir_change(dir_change), .err_ack(err_ack),
    .start_pos_req(start_pos_req), .start_man_req(start_man_req), .start_grant(start_grant),
    .start_refused(start_refused), .range_end(range_end), .hold_torque_cap(hold_torque_cap),
    .rotation_ccw(rotation_ccw), .reversal_idle(reversal_idle), .motor_power_ok(motor_power_ok)
  );

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask : chk_bit
  task automatic report_and_stop();
    $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic acc(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    u_master.xfer(wr, idx, wd, ab, rd, ok);
    if (ok !== 1'h1) begin
      fail_count++;
      $display("MISMATCH t=%0t no answer", $time);
      report_and_stop();
    end
  endtask : acc

  initial begin
    forever #2 clock = ~clock;
  end
  initial begin
    #40000;
    fail_count++;
    $display("MISMATCH t=%0t timeout", $time);
    report_and_stop();
  end
  initial begin
    repeat (3) @(negedge clock);
    rst_n = '1;
    foreach (rows[i]) begin
      acc(rows[i].wr, rows[i].idx, rows[i].wd);
      chk_bit(ab, rows[i].ab);
      chk_word(rd, rows[i].rd);
    end
    chk_word(range_end, 32'h3F400);
    chk_word({16'h0, hold_torque_cap}, 32'hFFFF);
    $display("Table test done");
    foreach (st_pos[i]) begin
      evt = dsr_evt_t'(14'h2000 >> i);
      acc('0, 16'h2025, '0);
      chk_word(rd, 32'h10 | (32'h1 << st_pos[i]));
    end
    evt = '0;
    $display("Status test done");
    evt.running = '1;
    acc('1, 16'h2028, 32'h1000);
    chk_bit(ab, '1);
    acc('1, 16'h202C, '0);
    chk_bit(ab, '1);
    start_man_req = '1;
    #1 chk_bit(start_refused, '1);
    @(negedge clock);
    start_man_req = '0;
    meas.u_drive = 16'h00AF;
    #1 chk_bit(motor_power_ok, '1);
    @(negedge clock);
    meas.u_drive = 16'h00AE;
    #1 chk_bit(motor_power_ok, '0);
    @(negedge clock);
    evt.running = '0;
    #1 chk_bit(motor_power_ok, '0);
    @(negedge clock);
    meas.u_drive = 16'h00B9;
    start_pos_req = '1;
    #1 chk_bit(start_grant, '0);
    chk_bit(start_refused, '1);
    @(negedge clock);
    meas.u_drive = 16'h00BA;
    #1 chk_bit(start_grant, '1);
    @(negedge clock);
    start_pos_req = '0;
    start_man_req = '1;
    #1 chk_bit(start_grant, '1);
    @(negedge clock);
    start_man_req = '0;
    acc('0, 16'h2025, '0);
    chk_word(rd, 32'h2010);
    err_ack = '1;
    @(negedge clock);
    err_ack = '0;
    acc('0, 16'h2025, '0);
    chk_word(rd, 32'h10);
    acc('0, 16'h2028, '0);
    chk_word(rd, 32'h3F400);
    chk_bit(rotation_ccw, '1);
    $display("Standstill and voltage test done");
    dir_change = '1;
    @(negedge clock);
    dir_change = '0;
    n = 0;
    while (reversal_idle === 1'h1 && n < 100) begin
      n++;
      @(negedge clock);
    end
    chk_word(n, 32'h28);
    evt.running = '1;
    startup_phase = '1;
    meas.torque = 16'h0384;
    @(negedge clock);
    startup_phase = '0;
    meas.torque = 16'h01F4;
    @(negedge clock);
    meas.torque = 16'h012C;
    braking_phase = '1;
    @(negedge clock);
    meas.torque = 16'h0320;
    @(negedge clock);
    evt.running = '0;
    braking_phase = '0;
    acc('0, 16'h2031, '0);
    chk_word(rd, 32'h1F4);
    $display("Pause and torque test done");
    acc('1, 16'h202E, 32'h64);
    chk_bit(ab, '0);
    rst_n = '0;
    #1 chk_word(range_end, 32'h19000);
    chk_bit(rotation_ccw, '0);
    chk_word({16'h0, hold_torque_cap}, 32'h64);
    @(negedge clock);
    rst_n = '1;
    acc('0, 16'h202E, '0);
    chk_word(rd, 32'hA);
    $display("Reset test done");
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
